/* tb/pat_chan_model.sv */
// channel model that raises a cycle request and holds it over a block
`timescale 1ns/1ns
module pat_chan_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // bench control
  input  wire logic       go,
  input  wire logic [7:0] len,
  // request to the translator
  output logic            cycle_req
);
  logic [7:0] left_ff;
  logic [7:0] nxt_left;
  // request stays up until the whole block is counted down
  always_comb begin
    nxt_left = go ? len : (left_ff != 8'h00 ? left_ff - 8'h01 : left_ff);
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) left_ff <= 8'h00;
    else left_ff <= nxt_left;
  end
  assign cycle_req = left_ff != 8'h00;
endmodule

/* tb/pat_translator_chk.sv */
// assertion checker bound to the partition address translator
`timescale 1ns/1ns
module pat_translator_chk
  import pat_pkg::*;
(
  // clock and control
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic              ce,
  input wire logic [SIZE_W-1:0] common_size_k,
  input wire logic              io_controller_op,
  input wire logic              file_access_channel_cycle_req,
  input wire logic              xfer_start,
  input wire logic [CNT_W-1:0]  xfer_count,
  input wire logic              common_area_select,
  // memory and sequencer side
  input wire logic              mem_cycle,
  input wire logic [LOW_W-1:0]  mem_low_bcd,
  input wire logic [DIG_W-1:0]  mem_thou_digit,
  input wire logic [DIG_W-1:0]  mem_tenk_digit,
  input wire logic              seq_hold,
  input wire logic              xfer_busy,
  input wire logic              xfer_done,
  input wire logic              addr_error,
  input wire logic              check_preset,
  input wire logic              program_count_tens_digit_decr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // start taken with the channel quiet, then a quiet evaluation cycle
  sequence s_take;
    ce && xfer_start && !xfer_busy && xfer_count != 7'h00 && !file_access_channel_cycle_req;
  endsequence
  sequence s_quiet;
    !file_access_channel_cycle_req;
  endsequence
  // a fault closes the transfer and the sequencer goes idle
  sequence s_close;
    xfer_done ##1 !xfer_busy;
  endsequence

  a_first_answer:
    assert property (s_take ##1 s_quiet |=> mem_cycle || addr_error) else $error("no answer after start");
  a_err_copies:
    assert property ((addr_error || check_preset || program_count_tens_digit_decr)
      |-> addr_error && check_preset && program_count_tens_digit_decr) else $error("fault pulses differ");
  a_err_ends:
    assert property (addr_error |-> s_close) else $error("fault did not end transfer");
  a_err_nocycle:
    assert property (addr_error |-> !mem_cycle) else $error("memory cycle on fault");
  a_hold_req:
    assert property (seq_hold == file_access_channel_cycle_req) else $error("hold not following request");
  a_stall_scan:
    assert property ($past(file_access_channel_cycle_req) && $past(io_controller_op)
      |-> !mem_cycle) else $error("cycle while stalled");
  a_common_zero:
    assert property (mem_cycle && common_area_select |-> mem_tenk_digit == 4'h0
      && mem_thou_digit < common_size_k) else $error("common address offset or over limit");
  a_bcd_wires:
    assert property (mem_cycle |-> mem_low_bcd[11:8] <= BCD_NINE && mem_low_bcd[7:4] <= BCD_NINE
      && mem_low_bcd[3:0] <= BCD_NINE && mem_thou_digit <= BCD_NINE) else $error("digit not bcd");
endmodule

bind pat_translator pat_translator_chk pat_translator_chk_i (
  .core_clk, .reset, .ce, .common_size_k, .io_controller_op, .file_access_channel_cycle_req,
  .xfer_start, .xfer_count, .common_area_select, .mem_cycle, .mem_low_bcd, .mem_thou_digit,
  .mem_tenk_digit, .seq_hold, .xfer_busy, .xfer_done, .addr_error, .check_preset,
  .program_count_tens_digit_decr
);

/* tb/test_pat_translator.sv */
// self-checking bench for the partition address translator
`timescale 1ns/1ns
module test_pat_translator;
  import pat_pkg::*;
  logic        core_clk, reset, part_step, file_access_channel_op, file_access_channel_cycle_req;
  logic        xfer_start, xfer_read, common_area_select, inhibit_panel, inhibit_mode, go;
  logic        io_controller_op;
  logic        mem_cycle, mem_read, xfer_busy, addr_error;
  logic [3:0]  common_size_k, mem_thou_digit, mem_tenk_digit;
  logic [3:0]  sz [20];
  logic [79:0] part_size_k;
  logic [4:0]  part_num;
  logic [15:0] xfer_addr;
  logic [6:0]  xfer_count;
  logic [11:0] mem_low_bcd;
  logic [7:0]  len;
  logic [21:0] exp_note, got_note;
  logic [31:0] seed;
  logic [21:0] expq [$];
  int          miscompares, cmp_count;

  pat_translator pat_translator_i (
    .core_clk, .reset, .ce(1'b1), .common_size_k, .part_size_k, .part_step, .part_num,
    .io_controller_op, .file_access_channel_op, .file_access_channel_cycle_req, .xfer_start,
    .xfer_addr, .xfer_count, .xfer_read, .common_area_select, .inhibit_panel, .inhibit_mode,
    .mem_cycle, .mem_read, .mem_low_bcd, .mem_thou_digit, .mem_tenk_digit, .seq_hold(),
    .xfer_busy, .xfer_done(), .addr_error, .check_preset(), .program_count_tens_digit_decr()
  );
  pat_chan_model pat_chan_model_i (.core_clk, .reset, .go, .len, .cycle_req(file_access_channel_cycle_req));

  // helpers: random source, bcd step, partition base
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] bcd_inc(input logic [15:0] a);
    for (int d = 0; d < 4; d++) begin
      if (a[4*d+:4] != BCD_NINE) begin
        a[4*d+:4] = a[4*d+:4] + 4'h1;
        return a;
      end
      a[4*d+:4] = BCD_ZERO;
    end
    return a;
  endfunction
  function automatic logic [7:0] base_of(input int p);
    logic [7:0] b;
    b = {4'h0, common_size_k};
    for (int i = 0; i < p; i++) b = b + {4'h0, sz[i]};
    return b;
  endfunction

  task automatic check(input logic [21:0] got, input logic [21:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // note every expected cycle or fault, start the transfer, wait for idle
  task automatic xfer(input logic [15:0] a, input logic [6:0] n, input logic r, input logic c, input int p);
    logic [15:0] x;
    logic [7:0]  k, t, u;
    logic        flt;
    int          i;
    x = a;
    for (i = 0; i < n; i++) begin
      flt = c ? (x[15:12] >= common_size_k || (r && x < PROT_LIMIT && !(inhibit_mode || inhibit_panel)))
              : (sz[p] != TENK_SIZE && x[15:12] >= sz[p]);
      if (flt) begin
        expq.push_back({1'b1, 21'h00_0000});
        break;
      end
      k = (c ? BASE_ZERO : base_of(p)) + {4'h0, x[15:12]};
      t = k / DEC_RADIX;
      u = k % DEC_RADIX;
      expq.push_back({1'b0, r, t[3:0], u[3:0], x[11:0]});
      x = bcd_inc(x);
    end
    @(negedge core_clk);
    xfer_addr = a;
    xfer_count = n;
    xfer_read = r;
    common_area_select = c;
    xfer_start = 1'b1;
    @(negedge core_clk);
    xfer_start = 1'b0;
    for (i = 0; i < 400 && xfer_busy !== 1'b0; i++) @(negedge core_clk);
    if (xfer_busy !== 1'b0) begin
      miscompares++;
      results();
    end
    @(negedge core_clk);
    check(22'(expq.size()), 22'h00_0000);
  endtask

  task automatic step(input logic [4:0] p);
    @(negedge core_clk);
    part_num = p;
    part_step = 1'b1;
    @(negedge core_clk);
    part_step = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  // compare each memory cycle or fault with the oldest note
  always @(negedge core_clk) begin
    if (mem_cycle === 1'b1 || addr_error === 1'b1) begin
      exp_note = (expq.size() != 0) ? expq.pop_front() : 22'h3f_ffff;
      got_note = addr_error ? {1'b1, 21'h00_0000} : {1'b0, mem_read, mem_tenk_digit, mem_thou_digit, mem_low_bcd};
      check(got_note, exp_note);
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // stimulus
  initial begin
    reset = 1'b1;
    part_step = 1'b0;
    part_num = 5'h00;
    file_access_channel_op = 1'b0;
    io_controller_op = 1'b0;
    xfer_start = 1'b0;
    xfer_addr = 16'h0000;
    xfer_count = CNT_ONE;
    xfer_read = 1'b1;
    common_area_select = 1'b0;
    inhibit_panel = 1'b0;
    inhibit_mode = 1'b0;
    go = 1'b0;
    len = 8'h00;
    common_size_k = 4'h2;
    seed = 32'h0000_06eb;
    sz = '{default: 4'h1};
    sz[0] = 4'h2;
    sz[1] = 4'h5;
    sz[2] = 4'h3;
    sz[3] = 4'h7;
    sz[4] = TENK_SIZE;
    for (int i = 0; i < 20; i++) part_size_k[4*i+:4] = sz[i];
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    step(5'h03);
    xfer(16'h2304, 7'h02, 1'b1, 1'b0, 3);
    xfer(16'h6992, 7'h0a, 1'b1, 1'b0, 3);
    xfer(16'h8000, 7'h03, 1'b1, 1'b0, 3);
    step(5'h04);
    xfer(16'h9998, 7'h04, 1'b0, 1'b0, 4);
    xfer(16'h2500, 7'h02, 1'b0, 1'b1, 4);
    xfer(16'h1500, 7'h02, 1'b1, 1'b1, 4);
    xfer(16'h0250, 7'h02, 1'b1, 1'b1, 4);
    xfer(16'h0299, 7'h02, 1'b0, 1'b1, 4);
    inhibit_mode = 1'b1;
    xfer(16'h0298, 7'h02, 1'b1, 1'b1, 4);
    inhibit_mode = 1'b0;
    inhibit_panel = 1'b1;
    repeat (3) @(negedge core_clk);
    xfer(16'h0100, 7'h03, 1'b1, 1'b1, 4);
    inhibit_panel = 1'b0;
    repeat (3) @(negedge core_clk);
    step(5'h01);
    for (int j = 0; j < 8; j++) begin
      seed = lfsr(seed);
      xfer({4'(seed[7:0] % 8'h06), 4'(seed[15:8] % DEC_RADIX), 4'(seed[23:16] % DEC_RADIX), BCD_NINE},
           {5'h00, seed[25:24]} + CNT_ONE, seed[26], 1'b0, 1);
    end
    fork
      xfer(16'h0100, 7'h04, 1'b1, 1'b0, 1);
      begin
        repeat (3) @(negedge core_clk);
        io_controller_op = 1'b1;
        len = 8'h06;
        go = 1'b1;
        @(negedge core_clk);
        go = 1'b0;
        repeat (8) @(negedge core_clk);
        io_controller_op = 1'b0;
      end
    join
    step(5'h03);
    file_access_channel_op = 1'b1;
    step(5'h00);
    len = 8'h0c;
    go = 1'b1;
    @(negedge core_clk);
    go = 1'b0;
    xfer(16'h1304, 7'h02, 1'b1, 1'b0, 3);
    repeat (12) @(negedge core_clk);
    xfer(16'h1304, 7'h02, 1'b1, 1'b0, 0);
    file_access_channel_op = 1'b0;
    results();
  end
endmodule

/* verilog/pat_base_regs.sv */
// scan and working base registers with their partition numbers
`timescale 1ns/1ns
module pat_base_regs
  import pat_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              ce,
  // partition step from the base adder
  input  wire logic              step,
  input  wire logic [PART_W-1:0] step_part,
  input  wire logic [BASE_W-1:0] step_base,
  // mode gating
  input  wire logic              fac_op,
  input  wire logic              use_work,
  // selected base
  output logic       [BASE_W-1:0] sel_base,
  output logic       [PART_W-1:0] sel_part
);

  logic [BASE_W-1:0] scan_base_ff, nxt_scan_base;
  logic [PART_W-1:0] scan_part_ff, nxt_scan_part;
  logic [BASE_W-1:0] work_base_ff, nxt_work_base;
  logic [PART_W-1:0] work_part_ff, nxt_work_part;
  logic              fac_op_ff,    nxt_fac_op;

  // scan register follows every step; working register is frozen while a channel operation runs
  always_comb begin
    nxt_scan_base = scan_base_ff;
    nxt_scan_part = scan_part_ff;
    nxt_work_base = work_base_ff;
    nxt_work_part = work_part_ff;
    nxt_fac_op    = fac_op;
    if (step) begin
      nxt_scan_base = step_base;
      nxt_scan_part = step_part;
    end
    if (!fac_op) begin
      nxt_work_base = nxt_scan_base;
      nxt_work_part = nxt_scan_part;
    end
  end

  // register the base pair
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scan_base_ff <= BASE_ZERO;
      scan_part_ff <= '0;
      work_base_ff <= BASE_ZERO;
      work_part_ff <= '0;
      fac_op_ff    <= 1'b0;
    end else if (ce) begin
      scan_base_ff <= nxt_scan_base;
      scan_part_ff <= nxt_scan_part;
      work_base_ff <= nxt_work_base;
      work_part_ff <= nxt_work_part;
      fac_op_ff    <= nxt_fac_op;
    end
  end

  // mode gate: channel cycle during a channel operation takes the working base, all else the scan base
  assign sel_base = (use_work && fac_op_ff) ? work_base_ff : scan_base_ff;
  assign sel_part = (use_work && fac_op_ff) ? work_part_ff : scan_part_ff;

endmodule

/* verilog/pat_pkg.sv */
// package of constants and types for the partition address translator
package pat_pkg;

  // partition and digit geometry
  localparam int PART_CNT = 20;   // partitions served
  localparam int PART_W   = 5;    // width of a partition number
  localparam int SIZE_W   = 4;    // patched size of one area, in thousands
  localparam int BASE_W   = 8;    // base address, in thousands, binary
  localparam int DIG_W    = 4;    // one bcd digit
  localparam int ADDR_W   = 16;   // four bcd digits of relative address
  localparam int LOW_W    = 12;   // units, tens and hundreds on twelve wires
  localparam int CNT_W    = 7;    // characters in one transfer, up to 127

  // digit positions inside a relative address
  localparam int THOU_LSB = 12;
  localparam int HUND_LSB = 8;
  localparam int TENS_LSB = 4;
  localparam int UNIT_LSB = 0;

  // fixed values
  localparam logic [SIZE_W-1:0] TENK_SIZE  = 4'ha;      // partition of exactly ten thousand
  localparam logic [ADDR_W-1:0] PROT_LIMIT = 16'h0300;  // protected low common area
  localparam logic [DIG_W-1:0]  BCD_NINE   = 4'h9;
  localparam logic [DIG_W-1:0]  BCD_ZERO   = 4'h0;
  localparam logic [BASE_W-1:0] DEC_RADIX  = 8'h0a;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 7'h01;
  localparam logic [BASE_W-1:0] BASE_ZERO  = 8'h00;

  // transfer sequencer states, gray along idle -> run -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } pat_state_e;

endpackage

/* verilog/pat_translator.sv */
// partition address translator: base adder, limit checks and character transfer sequencer
// Notes on behaviour
// - units, tens, hundreds go to memory as twelve-wire bcd; thousands add base.
// - ten-thousands digit comes from the base sum on its own output.
// - ten-thousand partition wraps 9999 to 0000 and never faults in its own area.
// - ten-thousand partition in common area is limit checked like any other.
// - address checked before each memory cycle; an oversize address suppresses the cycle.
// - transfer stores up to the limit, faults at first character beyond it.
// - absolute address is relative plus common size plus lower partition sizes.
// - common address forces zero into base adder; thousands digit passes unchanged.
// - common thousands digit at or above the common limit raises an error.
// - read into common below 300 faults unless inhibit switch condition is active.
// - any fault presets check, decrements program count digit, ends the transfer.
// - partition zero base is the common limit; later bases add lower sizes.
// - each partition step computes a new base, held in two base registers.
// - during channel operation working base holds while scan base keeps stepping.
// - channel cycle request suspends sequencing during an io controller operation, otherwise runs on the working base while a channel operation is up.
// - channel holds request over the whole block; on release scanning resumes.
// - mode gating picks which base register feeds the address.
`timescale 1ns/1ns
module pat_translator
  import pat_pkg::*;
(
  // clock, reset and freeze
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  input  wire logic                       ce,
  // patched sizes
  input  wire logic [SIZE_W-1:0]          common_size_k,
  input  wire logic [PART_CNT*SIZE_W-1:0] part_size_k,
  // partition stepping from the sequencer
  input  wire logic                       part_step,
  input  wire logic [PART_W-1:0]          part_num,
  // mode gating
  input  wire logic                       io_controller_op,
  input  wire logic                       file_access_channel_op,
  input  wire logic                       file_access_channel_cycle_req,
  // transfer request
  input  wire logic                       xfer_start,
  input  wire logic [ADDR_W-1:0]          xfer_addr,
  input  wire logic [CNT_W-1:0]           xfer_count,
  input  wire logic                       xfer_read,
  input  wire logic                       common_area_select,
  // inhibit switch sources
  input  wire logic                       inhibit_panel,
  input  wire logic                       inhibit_mode,
  // memory select side
  output logic                            mem_cycle,
  output logic                            mem_read,
  output logic [LOW_W-1:0]                mem_low_bcd,
  output logic [DIG_W-1:0]                mem_thou_digit,
  output logic [DIG_W-1:0]                mem_tenk_digit,
  // sequencer side
  output logic                            seq_hold,
  output logic                            xfer_busy,
  output logic                            xfer_done,
  output logic                            addr_error,
  output logic                            check_preset,
  output logic                            program_count_tens_digit_decr
);

  // bcd increment of a four digit address, 9999 rolls to 0000
  function automatic logic [ADDR_W-1:0] bcd_inc(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    logic              carry;
    r     = a;
    carry = 1'b1;
    for (int d = 0; d < ADDR_W / DIG_W; d++) begin
      if (carry) begin
        if (a[d*DIG_W +: DIG_W] == BCD_NINE) begin
          r[d*DIG_W +: DIG_W] = BCD_ZERO;
        end else begin
          r[d*DIG_W +: DIG_W] = a[d*DIG_W +: DIG_W] + 4'h1;
          carry               = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // patched size of one partition from the flat patch bus
  function automatic logic [SIZE_W-1:0] size_of(input logic [PART_CNT*SIZE_W-1:0] sizes,
                                                input logic [PART_W-1:0] p);
    logic [SIZE_W-1:0] s;
    s = '0;
    for (int i = 0; i < PART_CNT; i++) begin
      if (p == PART_W'(i)) begin
        s = sizes[i*SIZE_W +: SIZE_W];
      end
    end
    return s;
  endfunction

  // inhibit switch from the test panel is a pin: two stage synchroniser
  logic inh_meta_ff, inh_sync_ff;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      inh_meta_ff <= 1'b0;
      inh_sync_ff <= 1'b0;
    end else if (ce) begin
      inh_meta_ff <= inhibit_panel;
      inh_sync_ff <= inh_meta_ff;
    end
  end

  // base adder: running sum of common size and lower partition sizes
  logic [BASE_W-1:0] prefix [0:PART_CNT];
  assign prefix[0] = BASE_W'(common_size_k);
  genvar gi;
  generate
    for (gi = 0; gi < PART_CNT; gi++) begin : g_prefix
      assign prefix[gi+1] = prefix[gi] + BASE_W'(part_size_k[gi*SIZE_W +: SIZE_W]);
    end
  endgenerate

  // pick the base of the partition being stepped to
  logic [BASE_W-1:0] step_base;
  always_comb begin
    step_base = BASE_ZERO;
    for (int i = 0; i < PART_CNT; i++) begin
      if (part_num == PART_W'(i)) begin
        step_base = prefix[i];
      end
    end
  end

  // channel cycle gates the working base only during a channel operation, not an io one
  logic              use_work;
  logic [BASE_W-1:0] sel_base;
  logic [PART_W-1:0] sel_part;
  assign use_work = file_access_channel_cycle_req && !io_controller_op;

  pat_base_regs u_base (
    .core_clk  (core_clk),
    .reset     (reset),
    .ce        (ce),
    .step      (part_step),
    .step_part (part_num),
    .step_base (step_base),
    .fac_op    (file_access_channel_op),
    .use_work  (use_work),
    .sel_base  (sel_base),
    .sel_part  (sel_part)
  );

  // seq_hold follows the channel request; the sequencer stalls on it only while io_controller_op is also up
  assign seq_hold = file_access_channel_cycle_req;

  // transfer sequencer state
  pat_state_e        state_ff,  nxt_state;
  logic [ADDR_W-1:0] addr_ff,   nxt_addr;
  logic [CNT_W-1:0]  cnt_ff,    nxt_cnt;
  logic              read_ff,   nxt_read;
  logic              com_ff,    nxt_com;

  // memory select and error outputs
  logic              cyc_ff,    nxt_cyc;
  logic              mrd_ff,    nxt_mrd;
  logic [LOW_W-1:0]  low_ff,    nxt_low;
  logic [DIG_W-1:0]  thou_ff,   nxt_thou;
  logic [DIG_W-1:0]  tenk_ff,   nxt_tenk;
  logic              err_ff,    nxt_err;

  // limit check on the current character address
  logic [DIG_W-1:0]  cur_thou;
  logic [SIZE_W-1:0] cur_size;
  logic              inhibit_sw;
  logic              fault;
  always_comb begin
    cur_thou   = addr_ff[THOU_LSB +: DIG_W];
    cur_size   = size_of(part_size_k, sel_part);
    inhibit_sw = inh_sync_ff || inhibit_mode;
    fault      = 1'b0;
    if (com_ff) begin
      if (cur_thou >= common_size_k) begin
        fault = 1'b1;
      end
      if (read_ff && (addr_ff < PROT_LIMIT) && !inhibit_sw) begin
        fault = 1'b1;
      end
    end else if ((cur_size != TENK_SIZE) && (cur_thou >= cur_size)) begin
      fault = 1'b1;
    end
  end

  // absolute thousands: base plus thousands digit, zero base for common area
  logic [BASE_W-1:0] abs_k;
  logic [BASE_W-1:0] abs_tenk;
  logic [BASE_W-1:0] abs_thou;
  always_comb begin
    abs_k    = (com_ff ? BASE_ZERO : sel_base) + BASE_W'(cur_thou);
    abs_tenk = abs_k / DEC_RADIX;
    abs_thou = abs_k % DEC_RADIX;
  end

  // next values of the sequencer and its outputs
  always_comb begin
    nxt_state = state_ff;
    nxt_addr  = addr_ff;
    nxt_cnt   = cnt_ff;
    nxt_read  = read_ff;
    nxt_com   = com_ff;
    nxt_cyc   = 1'b0;
    nxt_mrd   = mrd_ff;
    nxt_low   = low_ff;
    nxt_thou  = thou_ff;
    nxt_tenk  = tenk_ff;
    nxt_err   = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (xfer_start && (xfer_count != '0)) begin
          nxt_state = ST_RUN;
          nxt_addr  = xfer_addr;
          nxt_cnt   = xfer_count;
          nxt_read  = xfer_read;
          nxt_com   = common_area_select;
        end
      end
      ST_RUN: begin
        if (seq_hold && !use_work) begin
          nxt_state = ST_RUN;
        end else if (fault) begin
          nxt_err   = 1'b1;
          nxt_state = ST_DONE;
        end else begin
          nxt_cyc   = 1'b1;
          nxt_mrd   = read_ff;
          nxt_low   = addr_ff[UNIT_LSB +: LOW_W];
          nxt_thou  = abs_thou[DIG_W-1:0];
          nxt_tenk  = abs_tenk[DIG_W-1:0];
          nxt_addr  = bcd_inc(addr_ff);
          nxt_cnt   = cnt_ff - CNT_ONE;
          if (cnt_ff == CNT_ONE) begin
            nxt_state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // register the sequencer and outputs
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      addr_ff  <= '0;
      cnt_ff   <= '0;
      read_ff  <= 1'b0;
      com_ff   <= 1'b0;
      cyc_ff   <= 1'b0;
      mrd_ff   <= 1'b0;
      low_ff   <= '0;
      thou_ff  <= BCD_ZERO;
      tenk_ff  <= BCD_ZERO;
      err_ff   <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      addr_ff  <= nxt_addr;
      cnt_ff   <= nxt_cnt;
      read_ff  <= nxt_read;
      com_ff   <= nxt_com;
      cyc_ff   <= nxt_cyc;
      mrd_ff   <= nxt_mrd;
      low_ff   <= nxt_low;
      thou_ff  <= nxt_thou;
      tenk_ff  <= nxt_tenk;
      err_ff   <= nxt_err;
    end
  end

  // output drive
  assign mem_cycle                     = cyc_ff;
  assign mem_read                      = mrd_ff;
  assign mem_low_bcd                   = low_ff;
  assign mem_thou_digit                = thou_ff;
  assign mem_tenk_digit                = tenk_ff;
  assign xfer_busy                     = (state_ff != ST_IDLE);
  assign xfer_done                     = (state_ff == ST_DONE);
  assign addr_error                    = err_ff;
  assign check_preset                  = err_ff;
  assign program_count_tens_digit_decr = err_ff;

endmodule
